// ### rtl/quad_counter_params.svh
// Behaviour
// - reset clears position counter, position latch and returns inhibit logic to idle
// - reset acts asynchronously, without any clock edge
// - data port is driven only while the active-low output enable is low
// - inhibit logic samples output enable and byte select on falling clock edge
// - byte select 0 presents high byte, 1 presents low byte, combinationally
// - one decoder count pulse per valid quadrature state transition
// - direction output high while counting up, low while counting down
// - direction changes on the same rising clock edge on which the count or cascade pulse rises
// - cascade pulse on each overflow or underflow of the position counter
// - latch is read through the 8-bit port as two byte transfers
// - twelve-bit variant forces the upper four bits of the high byte to zero
// - filtered channel changes only after two equal consecutive rising-edge samples
// - count every edge of both channels; A leading B counts up
// - binary up/down counter, 12 or 16 bits wide
`ifndef QUAD_COUNTER_PARAMS_SVH
`define QUAD_COUNTER_PARAMS_SVH
`define QC_POS_WIDTH      16
`define QC_SMALL_WIDTH    12
`define QC_FILTER_STAGES  3
`define QC_POS_RESET      16'h0000
`define QC_SEL_HIGH       1'b0
`define QC_SEL_LOW        1'b1
`endif

// ### rtl/quad_counter_pkg.sv
package quad_counter_pkg;
  // inhibit logic states
  typedef enum logic [1:0] {INH_IDLE, INH_HOLD, INH_RELEASE} inhibit_e;
  typedef logic [15:0] position_t;
endpackage

// ### rtl/input_filter.sv
`timescale 1ns/1ps
`include "quad_counter_params.svh"
module input_filter
(
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic raw_in,
  output logic      level_out
);
  // three sampling flops; first one feeds only the second
  logic [2:0] samp_r;
  logic       level_r;
  wire        agree = (samp_r[1] == samp_r[2]);

  // sample chain, rising edges
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      samp_r <= 3'h0;
    else
      samp_r <= {samp_r[1:0], raw_in};
  end

  // level follows only when the last stages agree, rejecting short spikes
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      level_r <= 1'b0;
    else if (agree)
      level_r <= samp_r[2];
  end

  assign level_out = level_r;

  a_filter_stable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (level_r != $past(level_r)) |-> ($past(samp_r[2]) == $past(samp_r[1])))
    else $error("filtered level changed without stable samples");
endmodule // input_filter

// ### rtl/quadrature_counter_bus_port.sv
`timescale 1ns/1ps
`include "quad_counter_params.svh"
module quadrature_counter_bus_port
#(
  parameter bit SMALL_COUNTER = 1'b0  // 1 selects the 12-bit variant
)
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       encoder_phase_a_in,
  input  wire logic       encoder_phase_b_in,
  input  wire logic       out_en_n_in,
  input  wire logic       byte_sel_in,
  output logic      [7:0] host_data_port_out,
  output logic      [7:0] host_data_port_oe_n_out,
  output logic            decoder_count_pulse_out,
  output logic            count_up_out,
  output logic            cascade_wrap_pulse_out
);
  logic                           filt_a;
  logic                           filt_b;
  logic                           prev_a_r;
  logic                           prev_b_r;
  quad_counter_pkg::position_t    count_r;
  quad_counter_pkg::position_t    count_nxt;
  quad_counter_pkg::position_t    latch_r;
  quad_counter_pkg::inhibit_e     inh_r;
  quad_counter_pkg::inhibit_e     inh_nxt;
  logic                           oe_n_fall_r;
  logic                           sel_fall_r;
  logic                           dcdr_r;
  logic                           cas_r;
  logic                           up_r;

  // one filter per channel
  input_filter u_filt_a
  (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .raw_in      (encoder_phase_a_in),
    .level_out   (filt_a)
  );

  input_filter u_filt_b
  (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .raw_in      (encoder_phase_b_in),
    .level_out   (filt_b)
  );

  // 4x decode: a change of exactly one filtered channel is one step
  wire a_chg   = filt_a ^ prev_a_r;
  wire b_chg   = filt_b ^ prev_b_r;
  wire step    = a_chg ^ b_chg;
  // a leading b: after an a edge, a differs from b; after a b edge, they match
  wire dir_up  = a_chg ? (filt_a != filt_b) : (filt_a == filt_b);
  wire [15:0] top_val = SMALL_COUNTER ? 16'h0fff : 16'hffff;
  wire at_top  = (count_r == top_val);
  wire at_zero = (count_r == 16'h0000);
  wire wrap    = step && (dir_up ? at_top : at_zero);

  // named next values keep the counter mux flat; the end points wrap instead
  // of spilling into bits that the 12-bit variant must keep at zero
  wire [15:0] count_inc = at_top ? 16'h0000 : count_r + 16'h0001;
  wire [15:0] count_dec = at_zero ? top_val : count_r - 16'h0001;

  // binary up/down counter, 12-bit variant wraps inside its own range
  assign count_nxt = !step ? count_r : (dir_up ? count_inc : count_dec);

  // decoder history, counter and direction
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev_a_r <= 1'b0;
      prev_b_r <= 1'b0;
      count_r  <= `QC_POS_RESET;
      up_r     <= 1'b1;
    end
    else
    begin
      prev_a_r <= filt_a;
      prev_b_r <= filt_b;
      count_r  <= count_nxt;
      if (step)
        up_r <= dir_up;
    end
  end

  // pulses rise at the clock rise after the step and fall at the next clock rise;
  // direction is updated on that same edge, together with the pulse
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dcdr_r <= 1'b0;
      cas_r  <= 1'b0;
    end
    else
    begin
      dcdr_r <= step;
      cas_r  <= wrap;
    end
  end

  // negedge sampling of host controls for the inhibit logic
  always_ff @(negedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      oe_n_fall_r <= 1'b1;
      sel_fall_r  <= `QC_SEL_HIGH;
    end
    else
    begin
      oe_n_fall_r <= out_en_n_in;
      sel_fall_r  <= byte_sel_in;
    end
  end

  // inhibit sequence: freeze on enable, release after low byte and enable high
  always_comb
  begin
    inh_nxt = inh_r;
    case (inh_r)
      quad_counter_pkg::INH_IDLE:
        if (!oe_n_fall_r)
          inh_nxt = (sel_fall_r == `QC_SEL_LOW) ? quad_counter_pkg::INH_RELEASE
                                                : quad_counter_pkg::INH_HOLD;
      quad_counter_pkg::INH_HOLD:
        if (!oe_n_fall_r && sel_fall_r == `QC_SEL_LOW)
          inh_nxt = quad_counter_pkg::INH_RELEASE;
      quad_counter_pkg::INH_RELEASE:
        if (oe_n_fall_r)
          inh_nxt = quad_counter_pkg::INH_IDLE;
      default:
        inh_nxt = quad_counter_pkg::INH_IDLE;
    endcase
  end

  wire inhibit = (inh_r != quad_counter_pkg::INH_IDLE) || !oe_n_fall_r;

  // inhibit state and latch, both on the rising edge
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      inh_r   <= quad_counter_pkg::INH_IDLE;
      latch_r <= `QC_POS_RESET;
    end
    else
    begin
      inh_r <= inh_nxt;
      if (!inhibit)
        latch_r <= count_r;
    end
  end

  // byte steering is combinational from select; masking covers the small variant
  wire [7:0] high_byte = SMALL_COUNTER ? {4'h0, latch_r[11:8]} : latch_r[15:8];
  wire [7:0] low_byte  = latch_r[7:0];
  assign host_data_port_out      = (byte_sel_in == `QC_SEL_HIGH) ? high_byte : low_byte;
  assign host_data_port_oe_n_out = {8{out_en_n_in}};
  assign decoder_count_pulse_out = dcdr_r;
  assign cascade_wrap_pulse_out  = cas_r;
  assign count_up_out            = up_r;


  // drive enable of the port follows the host enable pin
  a_drive_enable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    host_data_port_oe_n_out == {8{out_en_n_in}})
    else $error("data port drive does not follow output enable");

  // select 0 shows the high byte
  a_byte_steer: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (byte_sel_in == 1'b0) |-> host_data_port_out == high_byte)
    else $error("high byte not presented for select 0");

  // select 1 shows the low byte of the latch
  a_low_steer: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (byte_sel_in == 1'b1) |-> host_data_port_out == latch_r[7:0])
    else $error("low byte not presented for select 1");

  // full-width variant shows latch bits 15 to 8 as the high byte
  a_high_full: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!SMALL_COUNTER && byte_sel_in == 1'b0) |-> host_data_port_out == latch_r[15:8])
    else $error("high byte does not hold latch bits 15 to 8");

  // small variant never sets the upper nibble of the counter or the high byte
  a_small_mask: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    SMALL_COUNTER |-> (count_r[15:12] == 4'h0 && high_byte[7:4] == 4'h0))
    else $error("upper bits nonzero in small variant");

  // the latch of the small variant stays inside twelve bits too
  a_small_latch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    SMALL_COUNTER |-> latch_r[15:12] == 4'h0)
    else $error("latch upper bits nonzero in small variant");

  // while reset is held every edge sees the cleared state
  a_reset_clear: assert property (@(posedge core_clk_in)
    !rst_n_in |-> (count_r == 16'h0000 && latch_r == 16'h0000
                   && inh_r == quad_counter_pkg::INH_IDLE))
    else $error("state not cleared under reset");

  // every decoded step gives one pulse on the next edge
  a_count_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    step |=> decoder_count_pulse_out)
    else $error("no count pulse after decoder step");

  // no pulse without a step behind it
  a_pulse_cause: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    decoder_count_pulse_out |-> $past(step))
    else $error("count pulse without decoder step");

  // counting up away from the top end
  a_count_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (step && dir_up && !wrap) |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not increment");

  // counting down away from zero
  a_count_down: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (step && !dir_up && !wrap) |=> count_r == $past(count_r) - 16'h0001)
    else $error("counter did not decrement");

  // no step, no change: illegal double changes are dropped here
  a_count_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !step |=> $stable(count_r))
    else $error("counter moved without a step");

  // overflow lands on zero
  a_wrap_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (wrap && dir_up) |=> count_r == 16'h0000)
    else $error("overflow did not land on zero");

  // underflow lands on the top value of the variant
  a_wrap_top: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (wrap && !dir_up) |=> count_r == top_val)
    else $error("underflow did not land on top value");

  // direction takes the decoded sense at the step edge
  a_dir_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    step |=> count_up_out == $past(dir_up))
    else $error("direction does not follow decoded sense");

  // direction only moves on a step
  a_dir_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !step |=> $stable(count_up_out))
    else $error("direction moved without a step");

  // direction was set at the step edge, the same edge on which the pulse rises
  a_dir_before: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(decoder_count_pulse_out) |-> $past(step) && count_up_out == $past(dir_up))
    else $error("direction not settled at pulse");

  // same check at the edge on which the cascade pulse rises
  a_cas_dir: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(cascade_wrap_pulse_out) |-> $past(step) && count_up_out == $past(dir_up))
    else $error("direction not settled at cascade pulse");

  // every wrap gives a cascade pulse
  a_cas_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wrap |=> cascade_wrap_pulse_out)
    else $error("no cascade pulse after wrap");

  // and a cascade pulse only follows a wrap
  a_cascade_wrap: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cascade_wrap_pulse_out |-> $past(step) && ($past(count_r) == 16'h0000 || $past(count_r) == top_val))
    else $error("cascade pulse without wrap");

  // host controls are captured on the falling edge; the edge after reset is skipped
  a_fall_sample: assert property (@(negedge core_clk_in) disable iff (!rst_n_in)
    $past(rst_n_in) |-> (oe_n_fall_r == $past(out_en_n_in)
                        && sel_fall_r == $past(byte_sel_in)))
    else $error("host controls not captured on falling edge");

  // enable with high byte selected starts the hold
  a_inh_start: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (inh_r == quad_counter_pkg::INH_IDLE && !oe_n_fall_r && sel_fall_r == `QC_SEL_HIGH)
    |=> inh_r == quad_counter_pkg::INH_HOLD)
    else $error("hold not entered on enable");

  // hold stays until the low byte is seen
  a_inh_keep: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (inh_r == quad_counter_pkg::INH_HOLD && sel_fall_r == `QC_SEL_HIGH)
    |=> inh_r == quad_counter_pkg::INH_HOLD)
    else $error("hold left before low byte");

  // low byte under enable moves on to release
  a_inh_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (inh_r == quad_counter_pkg::INH_HOLD && !oe_n_fall_r && sel_fall_r == `QC_SEL_LOW)
    |=> inh_r == quad_counter_pkg::INH_RELEASE)
    else $error("release not entered after low byte");

  // enable high ends the read
  a_inh_end: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (inh_r == quad_counter_pkg::INH_RELEASE && oe_n_fall_r)
    |=> inh_r == quad_counter_pkg::INH_IDLE)
    else $error("inhibit not back to idle");

  // latch frozen through the whole read
  a_latch_freeze: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $past(inhibit) |-> $stable(latch_r))
    else $error("latch changed while inhibited");

  // latch tracks the counter otherwise
  a_latch_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !$past(inhibit) |-> latch_r == $past(count_r))
    else $error("latch not reloaded");
endmodule // quadrature_counter_bus_port

// ### tb/encoder_model.sv
`timescale 1ns/1ps
module encoder_model
(
  input  wire logic core_clk_in,
  input  wire logic step_in,
  input  wire logic up_in,
  input  wire logic glitch_in,
  output logic      phase_a_out,
  output logic      phase_b_out
);
  logic [1:0] state_r = 2'h0;
  // one quarter cycle per commanded step, moved on the rising edge after the
  // bench raised the command at a falling edge, so the command is never raced
  always @(posedge core_clk_in)
  begin
    if (step_in)
      state_r <= up_in ? state_r + 2'h1 : state_r - 2'h1;
  end
  // a leads b when stepping up; glitch is noise commanded by the bench only
  assign phase_a_out = state_r[0] ^ state_r[1] ^ glitch_in;
  assign phase_b_out = state_r[1];
endmodule // encoder_model

// ### tb/test_quadrature_counter_bus_port.sv
`timescale 1ns/1ps
module test_quadrature_counter_bus_port;
  logic        clk, rst_n, oe_n, sel, step, up, glitch, pha, phb;
  logic        cnt_p, dir_up, wrap_p;
  logic [7:0]  data, data_oe_n, data_s;
  logic [15:0] v;
  int          errors, n_tests, n_cnt, n_wrap, ext_pos;

  quadrature_counter_bus_port dut
  (
    .core_clk_in(clk), .rst_n_in(rst_n), .encoder_phase_a_in(pha),
    .encoder_phase_b_in(phb), .out_en_n_in(oe_n), .byte_sel_in(sel),
    .host_data_port_out(data), .host_data_port_oe_n_out(data_oe_n),
    .decoder_count_pulse_out(cnt_p), .count_up_out(dir_up),
    .cascade_wrap_pulse_out(wrap_p)
  );
  // twelve-bit variant on the same encoder and host lines
  quadrature_counter_bus_port #(.SMALL_COUNTER(1'b1)) dut_small
  (
    .core_clk_in(clk), .rst_n_in(rst_n), .encoder_phase_a_in(pha),
    .encoder_phase_b_in(phb), .out_en_n_in(oe_n), .byte_sel_in(sel),
    .host_data_port_out(data_s), .host_data_port_oe_n_out(),
    .decoder_count_pulse_out(), .count_up_out(),
    .cascade_wrap_pulse_out()
  );
  encoder_model enc
  (
    .core_clk_in(clk), .step_in(step), .up_in(up), .glitch_in(glitch),
    .phase_a_out(pha), .phase_b_out(phb)
  );

  // 200 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // tally one-cycle event pulses where they stand
  always @(posedge clk)
  begin
    if (cnt_p === 1'b1)
      n_cnt++;
    if (wrap_p === 1'b1)
      n_wrap++;
  end

  // external range extension counter, steps on the cascade rise
  always @(posedge wrap_p)
  begin
    if (dir_up)
      ext_pos++;
    else
      ext_pos--;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // host read, high byte first, both bytes from one snapshot
  task automatic rd(output logic [15:0] val);
    @(negedge clk);
    oe_n <= 1'b0;
    sel  <= 1'b0;
    @(negedge clk);
    check({8'h00, data_oe_n}, 16'h0000);
    val[15:8] = data;
    sel <= 1'b1;
    @(negedge clk);
    val[7:0] = data;
    oe_n <= 1'b1;
    sel  <= 1'b0;
    @(negedge clk);
  endtask

  // one encoder step, then time for filter and decoder to settle
  task automatic mv(input logic dir);
    @(negedge clk);
    step <= 1'b1;
    up   <= dir;
    @(negedge clk);
    step <= 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic t_reset();
    check({8'h00, data_oe_n}, 16'h00ff);
    rd(v);
    check(v, 16'h0000);
  endtask

  task automatic t_up();
    repeat (3) mv(1'b1);
    rd(v);
    check(v, 16'h0003);
    check(n_cnt[15:0], 16'h0003);
    check({15'h0, dir_up}, 16'h0001);
  endtask

  // four steps down crosses zero, so the counter wraps to all ones
  task automatic t_down();
    repeat (4) mv(1'b0);
    rd(v);
    check(v, 16'hffff);
    check(n_wrap[15:0], 16'h0001);
    check({15'h0, dir_up}, 16'h0000);
    check(ext_pos[15:0], 16'hffff);
    repeat (2) @(negedge clk);
    check({8'h00, data_s}, 16'h000f);
  endtask

  // latch must hold while the counter moves under an open read
  task automatic t_freeze();
    @(negedge clk);
    oe_n <= 1'b0;
    sel  <= 1'b0;
    @(negedge clk);
    check({8'h00, data}, 16'h00ff);
    mv(1'b1);
    check({8'h00, data}, 16'h00ff);
    sel <= 1'b1;
    @(negedge clk);
    check({8'h00, data}, 16'h00ff);
    oe_n <= 1'b1;
    sel  <= 1'b0;
    repeat (2) @(negedge clk);
    rd(v);
    check(v, 16'h0000);
    check(n_wrap[15:0], 16'h0002);
    check(ext_pos[15:0], 16'h0000);
  endtask

  // a one-cycle spike must never reach the decoder
  task automatic t_glitch();
    @(negedge clk);
    glitch <= 1'b1;
    @(negedge clk);
    glitch <= 1'b0;
    repeat (8) @(negedge clk);
    check(n_cnt[15:0], 16'h0008);
  endtask

  // reset lands between clock edges and must clear the latch at once
  task automatic t_async();
    mv(1'b1);
    @(negedge clk);
    oe_n <= 1'b0;
    sel  <= 1'b1;
    #1 rst_n = 1'b0;
    #1 check({8'h00, data}, 16'h0000);
    @(negedge clk);
    rst_n <= 1'b1;
    oe_n  <= 1'b1;
  endtask

  task automatic end_of_test();
    $display("errors %0d, checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    rst_n  = 1'b0;
    oe_n   = 1'b1;
    sel    = 1'b0;
    step   = 1'b0;
    up     = 1'b1;
    glitch = 1'b0;
    repeat (5) @(negedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_up();
    t_down();
    t_freeze();
    t_glitch();
    t_async();
    end_of_test();
  end

  // watchdog, far beyond the roughly 130 cycles the run needs
  initial
  begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule // test_quadrature_counter_bus_port
